// ---- design/ddsf_pkg.sv ----
// shared constants for the synthesizer control front end and its serial host
package ddsf_pkg;
   // master clock and serial link timing
   localparam int CLK_NS = 100;
   localparam int SCLK_HALF_NS = 400;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int DIV_W = 4;
   // datapath widths
   localparam int WORD_BITS = 16;
   localparam int BITCNT_W = 5;
   localparam int ACC_BITS = 28;
   localparam int HALF_BITS = 14;
   localparam int PHASE_BITS = 12;
   // serial word layout: two top bits steer the word
   localparam int DEST_HI = 15;
   localparam int DEST_LO = 14;
   localparam logic [1:0] DEST_CTRL = 2'h0;
   localparam logic [1:0] DEST_FREQ_A = 2'h1;
   localparam logic [1:0] DEST_FREQ_B = 2'h2;
   localparam logic [1:0] DEST_PHASE = 2'h3;
   localparam int PHASE_PICK_POS = 13;
   // control word bit positions
   localparam int CTRL_HALF_POS = 12;
   localparam int CTRL_FREQ_POS = 11;
   localparam int CTRL_PHASE_POS = 10;
   localparam int CTRL_PINSEL_POS = 9;
   localparam int CTRL_SLEEP_POS = 7;
   localparam int CTRL_OE_POS = 5;
   localparam int CTRL_SIGN_POS = 4;
   // reset values of the addressable registers
   localparam logic [WORD_BITS-1:0] CTRL_RST = 16'h0000;
   localparam logic [ACC_BITS-1:0] FREQ_RST = 28'h0000000;
   localparam logic [PHASE_BITS-1:0] PHASE_RST = 12'h000;
   // host register map (byte addresses) and fields
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] REG_PINS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
   localparam int PIN_FREQ_POS = 0;
   localparam int PIN_PHASE_POS = 1;
   localparam int PIN_RESET_POS = 2;
   localparam int PIN_SLEEP_POS = 3;
   localparam int PINS_W = 4;
   localparam logic [PINS_W-1:0] PINS_RST = 4'h0;
   // synchroniser reset levels; serial clock (bit 0) and strobe (bit 2) idle high
   localparam logic [7:0] SYNC_RST = 8'h05;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // host serial engine states
   typedef enum logic [1:0] {
      HS_IDLE = 2'b01,
      HS_SHIFT = 2'b10
   } ddsf_hstate_type;
endpackage : ddsf_pkg

// ---- design/ddsf_link_if.sv ----
// pins between the serial host and the synthesizer front end
`timescale 1ns/10ps
`default_nettype none
interface ddsf_link_if;
   logic sclk;
   logic serial_data_in;
   logic frame_strobe_n;
   logic freq_choice_pin;
   logic phase_choice_pin;
   logic dds_reset;
   logic sleep;
   logic sign_out;
   logic sign_oe_n;
   wire sign_pin;
   // pin level: a released pin reads low, as if pulled down on the board
   assign sign_pin = !sign_oe_n && sign_out;
   modport device (
      input sclk, serial_data_in, frame_strobe_n, freq_choice_pin, phase_choice_pin, dds_reset, sleep,
      output sign_out, sign_oe_n
   );
   modport host (
      output sclk, serial_data_in, frame_strobe_n, freq_choice_pin, phase_choice_pin, dds_reset, sleep,
      input sign_out, sign_oe_n
   );
endinterface : ddsf_link_if
`default_nettype wire

// ---- design/ddsf_device.sv ----
// synthesizer control front end: serial loader, selection, accumulator and sign pin
`timescale 1ns/10ps
`default_nettype none
module ddsf_device (
   input wire logic aclk,
   input wire logic aresetn,
   ddsf_link_if.device link,
   input wire logic comparator_input,
   output logic [ddsf_pkg::PHASE_BITS-1:0] phase_word,
   output logic dac_powerdown,
   output logic [ddsf_pkg::WORD_BITS-1:0] word_count
);
   import ddsf_pkg::*;

   localparam int NSYNC = 8;

   logic [NSYNC-1:0] sync1_r;
   logic [NSYNC-1:0] sync2_r;
   logic [NSYNC-1:0] pin_raw;
   logic sclk_s;
   logic serial_data_in_s;
   logic frame_strobe_n_s;
   logic fpin_s;
   logic ppin_s;
   logic rst_s;
   logic sleep_s;
   logic comp_s;
   logic sclk_prev_r;
   logic sclk_fall;
   logic [WORD_BITS-1:0] shift_r;
   logic [WORD_BITS-1:0] shift_nxt;
   logic [BITCNT_W-1:0] bits_r;
   logic word_done;
   logic [WORD_BITS-1:0] ctrl_r;
   logic [ACC_BITS-1:0] freq_a_r;
   logic [ACC_BITS-1:0] freq_b_r;
   logic [PHASE_BITS-1:0] phase_a_r;
   logic [PHASE_BITS-1:0] phase_b_r;
   logic [ACC_BITS-1:0] acc_r;
   logic use_freq_b;
   logic use_phase_b;
   logic [ACC_BITS-1:0] freq_sel;
   logic [PHASE_BITS-1:0] phase_sel;
   logic sign_out_r;
   logic sign_oe_n_r;
   logic [PHASE_BITS-1:0] phase_word_r;
   logic dac_pd_r;
   logic [WORD_BITS-1:0] count_r;

   // merges a 14-bit half into either end of a 28-bit frequency word
   function automatic logic [ACC_BITS-1:0] merge_half(input logic [ACC_BITS-1:0] old,
                                                      input logic [HALF_BITS-1:0] half,
                                                      input logic upper);
      merge_half = upper ? {half, old[HALF_BITS-1:0]} : {old[ACC_BITS-1:HALF_BITS], half};
   endfunction : merge_half

   ////////////////////////////////////////////////////////////////////////
   // two-stage synchronisers for every pin from outside the master clock
   assign pin_raw = {comparator_input, link.sleep, link.dds_reset, link.phase_choice_pin,
                     link.freq_choice_pin, link.frame_strobe_n, link.serial_data_in, link.sclk};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               // idle levels, so release of reset shows no false clock fall or frame start
               sync1_r[gi] <= SYNC_RST[gi];
               sync2_r[gi] <= SYNC_RST[gi];
            end else begin
               sync1_r[gi] <= pin_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   // only the second stage is ever read
   assign sclk_s = sync2_r[0];
   assign serial_data_in_s = sync2_r[1];
   assign frame_strobe_n_s = sync2_r[2];
   assign fpin_s = sync2_r[3];
   assign ppin_s = sync2_r[4];
   assign rst_s = sync2_r[5];
   assign sleep_s = sync2_r[6];
   assign comp_s = sync2_r[7];

   ////////////////////////////////////////////////////////////////////////
   // serial loader: data and clock are delayed alike, so the fall samples a settled bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_prev_r <= 1'b1;
      end else begin
         sclk_prev_r <= sclk_s;
      end
   end

   assign sclk_fall = sclk_prev_r && !sclk_s;
   assign shift_nxt = {shift_r[WORD_BITS-2:0], serial_data_in_s};
   assign word_done = sclk_fall && !frame_strobe_n_s && (bits_r == BITCNT_W'(WORD_BITS - 1));

   // strobe high clears the count, so a high-to-low strobe always begins a fresh word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bits_r <= '0;
         shift_r <= '0;
      end else if (frame_strobe_n_s) begin
         bits_r <= '0;
      end else if (sclk_fall) begin
         shift_r <= shift_nxt;
         bits_r <= word_done ? '0 : bits_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // addressable registers: written only by whole words, never by the reset pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RST;
         freq_a_r <= FREQ_RST;
         freq_b_r <= FREQ_RST;
         phase_a_r <= PHASE_RST;
         phase_b_r <= PHASE_RST;
      end else if (word_done) begin
         unique case (shift_nxt[DEST_HI:DEST_LO])
            DEST_CTRL: ctrl_r <= shift_nxt;
            DEST_FREQ_A: freq_a_r <= merge_half(freq_a_r, shift_nxt[HALF_BITS-1:0], ctrl_r[CTRL_HALF_POS]);
            DEST_FREQ_B: freq_b_r <= merge_half(freq_b_r, shift_nxt[HALF_BITS-1:0], ctrl_r[CTRL_HALF_POS]);
            DEST_PHASE: begin
               if (shift_nxt[PHASE_PICK_POS]) begin
                  phase_b_r <= shift_nxt[PHASE_BITS-1:0];
               end else begin
                  phase_a_r <= shift_nxt[PHASE_BITS-1:0];
               end
            end
         endcase
      end
   end

   // words accepted, for software visibility of the link
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_r <= '0;
      end else if (word_done) begin
         count_r <= count_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register selection: pins are trusted held steady when the pin select bit lets them rule
   assign use_freq_b = ctrl_r[CTRL_PINSEL_POS] ? fpin_s : ctrl_r[CTRL_FREQ_POS];
   assign use_phase_b = ctrl_r[CTRL_PINSEL_POS] ? ppin_s : ctrl_r[CTRL_PHASE_POS];
   assign freq_sel = use_freq_b ? freq_b_r : freq_a_r;
   assign phase_sel = use_phase_b ? phase_b_r : phase_a_r;

   ////////////////////////////////////////////////////////////////////////
   // accumulator: only the increment changes on a switch, never the held phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_r <= '0;
      end else if (rst_s) begin
         acc_r <= '0;
      end else begin
         acc_r <= acc_r + freq_sel;
      end
   end

   // phase modulator output; zero phase maps to midscale downstream
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_word_r <= '0;
      end else if (rst_s) begin
         phase_word_r <= '0;
      end else begin
         phase_word_r <= acc_r[ACC_BITS-1 -: PHASE_BITS] + phase_sel;
      end
   end

   // converter power-down from pin or control bit, either one suffices
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dac_pd_r <= 1'b0;
      end else begin
         dac_pd_r <= sleep_s | ctrl_r[CTRL_SLEEP_POS];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sign pin: released unless enabled, source picked by the sign select bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sign_out_r <= 1'b0;
         sign_oe_n_r <= 1'b1;
      end else begin
         sign_oe_n_r <= !ctrl_r[CTRL_OE_POS];
         sign_out_r <= ctrl_r[CTRL_SIGN_POS] ? comp_s : acc_r[ACC_BITS-1];
      end
   end

   assign link.sign_out = sign_out_r;
   assign link.sign_oe_n = sign_oe_n_r;
   assign phase_word = phase_word_r;
   assign dac_powerdown = dac_pd_r;
   assign word_count = count_r;
endmodule : ddsf_device
`default_nettype wire

// ---- design/ddsf_host.sv ----
// serial host: AXI4-Lite registers driving the three-wire link and the select pins
`timescale 1ns/10ps
`default_nettype none
module ddsf_host (
   input wire logic aclk,
   input wire logic aresetn,
   ddsf_link_if.host link,
   input wire logic [ddsf_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ddsf_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import ddsf_pkg::*;

   ddsf_hstate_type state_r;
   logic wr_take;
   logic rd_take;
   logic start;
   logic [DIV_W-1:0] div_r;
   logic tick;
   logic [WORD_BITS-1:0] shift_r;
   logic [BITCNT_W-1:0] bits_r;
   logic sclk_r;
   logic frame_strobe_n_n_r;
   logic serial_data_in_r;
   logic [PINS_W-1:0] pins_r;
   logic [WORD_BITS-1:0] sent_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken together, one write in flight
   assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_r && !awready_r;
   assign start = wr_take && (s_axi_awaddr == REG_DATA) && (state_r == HS_IDLE) && (&s_axi_wstrb[1:0]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         awready_r <= wr_take;
         wready_r <= wr_take;
         if (wr_take) begin
            bvalid_r <= 1'b1;
            bresp_r <= (s_axi_awaddr == REG_DATA || s_axi_awaddr == REG_PINS) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // select, reset and sleep pins follow the pin register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins_r <= PINS_RST;
      end else if (wr_take && s_axi_awaddr == REG_PINS && s_axi_wstrb[0]) begin
         pins_r <= s_axi_wdata[PINS_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel
   assign rd_take = s_axi_arvalid && !rvalid_r && !arready_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= '0;
      end else begin
         arready_r <= rd_take;
         if (rd_take) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            unique case (s_axi_araddr)
               REG_DATA: rdata_r <= {16'h0000, shift_r};
               REG_PINS: rdata_r <= {28'h0000000, pins_r};
               REG_STATUS: rdata_r <= {sent_r, 15'h0000, (state_r != HS_IDLE)};
               default: begin
                  rdata_r <= '0;
                  rresp_r <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial clock divider: one-cycle tick each half period of the link clock
   assign tick = (div_r == DIV_W'(SCLK_HALF_CYC - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn || start || tick) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   // serial engine: data changes while the clock is high, device samples on the fall
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= HS_IDLE;
         sclk_r <= 1'b1;
         frame_strobe_n_n_r <= 1'b1;
         serial_data_in_r <= 1'b0;
         shift_r <= '0;
         bits_r <= '0;
      end else begin
         unique case (state_r)
            HS_IDLE: begin
               if (start) begin
                  state_r <= HS_SHIFT;
                  frame_strobe_n_n_r <= 1'b0;
                  shift_r <= s_axi_wdata[WORD_BITS-1:0];
                  serial_data_in_r <= s_axi_wdata[WORD_BITS-1];
                  bits_r <= '0;
               end
            end
            HS_SHIFT: begin
               if (tick && sclk_r) begin
                  sclk_r <= 1'b0;
                  bits_r <= bits_r + 1'b1;
               end else if (tick && bits_r == BITCNT_W'(WORD_BITS)) begin
                  sclk_r <= 1'b1;
                  frame_strobe_n_n_r <= 1'b1;
                  state_r <= HS_IDLE;
               end else if (tick) begin
                  sclk_r <= 1'b1;
                  shift_r <= {shift_r[WORD_BITS-2:0], 1'b0};
                  serial_data_in_r <= shift_r[WORD_BITS-2];
               end
            end
         endcase
      end
   end

   // count of completed words
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sent_r <= '0;
      end else if (state_r == HS_SHIFT && tick && !sclk_r && bits_r == BITCNT_W'(WORD_BITS)) begin
         sent_r <= sent_r + 1'b1;
      end
   end

   assign link.sclk = sclk_r;
   assign link.serial_data_in = serial_data_in_r;
   assign link.frame_strobe_n = frame_strobe_n_n_r;
   assign link.freq_choice_pin = pins_r[PIN_FREQ_POS];
   assign link.phase_choice_pin = pins_r[PIN_PHASE_POS];
   assign link.dds_reset = pins_r[PIN_RESET_POS];
   assign link.sleep = pins_r[PIN_SLEEP_POS];
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
endmodule : ddsf_host
`default_nettype wire

// ---- verif/ddsf_link_assertions.sv ----
// link checks between the serial host and the synthesizer front end
`timescale 1ns/10ps
`default_nettype none
module ddsf_link_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sclk,
   input wire logic serial_data_in,
   input wire logic frame_strobe_n,
   input wire logic sign_oe_n
);
   logic sclk_r;
   logic [4:0] falls_r;
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////
   // last sampled serial clock, for fall detection
   always_ff @(posedge aclk) begin
      sclk_r <= sclk;
   end
   // falls inside the current frame; a high strobe clears the count
   always_ff @(posedge aclk) begin
      if (!aresetn || frame_strobe_n) begin
         falls_r <= 5'h00;
      end else if (sclk_r && !sclk) begin
         falls_r <= falls_r + 5'h01;
      end
   end
   ////////////////////////////////////////////////////////////////
   property p_idle_high;
      frame_strobe_n |-> sclk;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("serial clock not high outside a frame");
   property p_frame_start;
      $fell(frame_strobe_n) |-> sclk [*2] ##[1:3] !sclk;
   endproperty
   a_frame_start: assert property (p_frame_start)
      else $error("first serial clock fall missing after strobe fall");
   property p_low_half;
      $fell(sclk) |-> (!sclk) [*4] ##1 sclk;
   endproperty
   a_low_half: assert property (p_low_half)
      else $error("serial clock low half has wrong length");
   property p_high_half;
      $rose(sclk) |-> sclk [*4];
   endproperty
   a_high_half: assert property (p_high_half)
      else $error("serial clock high half too short");
   property p_data_hold;
      !sclk |-> $stable(serial_data_in);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("serial data moved while clock low");
   property p_sixteen;
      $rose(frame_strobe_n) |-> falls_r == 5'h10;
   endproperty
   a_sixteen: assert property (p_sixteen)
      else $error("frame closed without sixteen clock falls");
   property p_gap;
      $rose(frame_strobe_n) |-> frame_strobe_n [*3];
   endproperty
   a_gap: assert property (p_gap)
      else $error("strobe high gap between frames too short");
   property p_after_reset;
      $rose(aresetn) |-> sign_oe_n && sclk && frame_strobe_n;
   endproperty
   a_after_reset: assert property (p_after_reset)
      else $error("link not idle with sign pin released after reset");
endmodule : ddsf_link_assertions
`default_nettype wire

// ---- verif/dds_digital_control_pins_bench.sv ----
// bench: host and front end on one link, a second front end on a hand-driven link
`timescale 1ns/10ps
`default_nettype none
module dds_digital_control_pins_bench;
   import ddsf_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic cmp_in = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pd, pd2;
   logic [1:0] bresp, rresp, rr;
   logic [31:0] rdata, rd;
   logic [11:0] pw, pw2, p1;
   logic [15:0] wc, wc2, words;
   logic [13:0] cv;
   int err_count = 0;
   int checks_done = 0;
   ddsf_link_if link ();
   ddsf_link_if link2 ();
   ddsf_host u_ddsf_host (.aclk(aclk), .aresetn(aresetn), .link(link), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   ddsf_device u_ddsf_device (.aclk(aclk), .aresetn(aresetn), .link(link), .comparator_input(cmp_in),
      .phase_word(pw), .dac_powerdown(pd), .word_count(wc));
   ddsf_device u_ddsf_device_b (.aclk(aclk), .aresetn(aresetn), .link(link2), .comparator_input(cmp_in),
      .phase_word(pw2), .dac_powerdown(pd2), .word_count(wc2));
   ddsf_link_assertions u_ddsf_link_assertions (.aclk(aclk), .aresetn(aresetn), .sclk(link.sclk),
      .serial_data_in(link.serial_data_in), .frame_strobe_n(link.frame_strobe_n), .sign_oe_n(link.sign_oe_n));
   ////////////////////////////////////////////////////////////////
   initial begin
      forever #50 aclk = ~aclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   // a wait that used up its bound counts against the run and ends it
   task automatic limit(input int n);
      if (n >= 200) begin
         err_count++;
         give_verdict();
      end
   endtask : limit
   function automatic logic [13:0] bv(input int p);
      return 14'h0001 << p;
   endfunction : bv
   ////////////////////////////////////////////////////////////////
   // address and data offered together, each dropped when taken; an idle edge follows
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 200);
      limit(n);
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 200);
      limit(n);
      d = rdata;
      rr = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axr
   // one word over the link; poll until idle, then both word counts must agree
   task automatic send(input logic [15:0] w);
      int n;
      logic [31:0] s;
      n = 0;
      axw(REG_DATA, {16'h0000, w}, RESP_OKAY);
      words++;
      do begin
         axr(REG_STATUS, s);
         n++;
      end while (s[0] !== 1'b0 && n < 200);
      limit(n);
      chk("word_count", {16'h0000, wc}, {16'h0000, words});
      chk("words_sent", {16'h0000, s[31:16]}, {16'h0000, words});
   endtask : send
   task automatic ctl(input logic [13:0] c);
      cv = c;
      send({DEST_CTRL, c});
   endtask : ctl
   // a 28-bit word goes in two halves, steered by the half bit of the control word
   task automatic freq(input logic [1:0] d, input logic [27:0] f);
      send({DEST_CTRL, cv});
      send({d, f[13:0]});
      send({DEST_CTRL, cv | bv(CTRL_HALF_POS)});
      send({d, f[27:14]});
   endtask : freq
   // pin levels stay put between calls, as the far side must keep them
   task automatic pins(input logic [3:0] p);
      logic [31:0] v;
      axw(REG_PINS, {28'h0000000, p}, RESP_OKAY);
      axr(REG_PINS, v);
      chk("pins_rd", v, {28'h0000000, p});
      tick(3);
   endtask : pins
   // a step of 2^14 moves the top 12 bits by exactly 100 in 400 cycles
   task automatic rate(input logic [11:0] step);
      logic [11:0] p0;
      p0 = pw;
      tick(400);
      chk("rate", {20'h0, pw - p0}, {20'h0, step});
   endtask : rate
   // hand-driven frame of nb bits, MSB first; data changes only while the clock is high
   task automatic drv2(input logic [15:0] w, input int nb);
      link2.frame_strobe_n <= 1'b0;
      for (int i = 15; i > 15 - nb; i--) begin
         link2.serial_data_in <= w[i];
         tick(4);
         link2.sclk <= 1'b0;
         tick(4);
         link2.sclk <= 1'b1;
      end
      tick(4);
      link2.frame_strobe_n <= 1'b1;
      link2.serial_data_in <= ~link2.serial_data_in;
      tick(8);
   endtask : drv2
   ////////////////////////////////////////////////////////////////
   initial begin
      link2.sclk = 1'b1;
      link2.serial_data_in = 1'b0;
      link2.frame_strobe_n = 1'b1;
      link2.freq_choice_pin = 1'b0;
      link2.phase_choice_pin = 1'b0;
      link2.dds_reset = 1'b0;
      link2.sleep = 1'b0;
      words = 16'h0000;
      cv = 14'h0000;
      tick(12);
      aresetn <= 1'b1;
      tick(4);
      axw(8'h0C, 32'h00000000, RESP_SLVERR);
      axr(8'h0C, rd);
      chk("rresp", {30'h0, rr}, {30'h0, RESP_SLVERR});
      chk("rdata", rd, 32'h00000000);
      freq(DEST_FREQ_A, 28'h0004000);
      freq(DEST_FREQ_B, 28'h0008000);
      send({DEST_PHASE, 2'b10, 12'h123});
      rate(12'h064);
      ctl(bv(CTRL_FREQ_POS));
      rate(12'h0C8);
      ctl(bv(CTRL_PINSEL_POS));
      rate(12'h064);
      pins(4'h1);
      rate(12'h0C8);
      freq(DEST_FREQ_B, 28'h0000000);
      pins(4'h4);
      chk("held", {20'h0, pw}, 32'h0);
      pins(4'h0);
      tick(10000);
      p1 = pw;
      pins(4'h1);
      chk("no_jump", {31'h0, 12'(pw - p1) <= 12'h003}, 32'h1);
      ctl(bv(CTRL_PINSEL_POS) | bv(CTRL_OE_POS));
      tick(4);
      chk("oe", {31'h0, link.sign_oe_n}, 32'h0);
      chk("msb", {31'h0, link.sign_pin}, 32'h1);
      ctl(cv | bv(CTRL_SIGN_POS));
      for (int i = 0; i < 2; i++) begin
         cmp_in <= ~cmp_in;
         tick(6);
         chk("cmp", {31'h0, link.sign_pin}, {31'h0, cmp_in});
      end
      ctl(bv(CTRL_PINSEL_POS));
      tick(4);
      chk("off", {31'h0, link.sign_oe_n}, 32'h1);
      p1 = pw;
      pins(4'h3);
      chk("offset", {20'h0, pw - p1}, 32'h123);
      pins(4'h7);
      chk("cleared", {20'h0, pw}, 32'h0);
      pins(4'h3);
      chk("kept", {20'h0, pw}, 32'h123);
      ctl(bv(CTRL_FREQ_POS));
      chk("bitsel", {20'h0, pw}, 32'h0);
      ctl(bv(CTRL_FREQ_POS) | bv(CTRL_PHASE_POS));
      chk("bitsel", {20'h0, pw}, 32'h123);
      pins(4'h8);
      chk("sleep", {31'h0, pd}, 32'h1);
      pins(4'h0);
      chk("awake", {31'h0, pd}, 32'h0);
      ctl(bv(CTRL_SLEEP_POS));
      chk("pd_bit", {31'h0, pd}, 32'h1);
      drv2(16'hC0FF, 9);
      chk("partial", {16'h0, wc2}, 32'h0);
      drv2(16'hC5A5, 16);
      chk("whole", {16'h0, wc2}, 32'h1);
      chk("msb_first", {20'h0, pw2}, 32'h5A5);
      give_verdict();
   end
endmodule : dds_digital_control_pins_bench
`default_nettype wire
